// File: src/psbm_core.sv
// Bus mode decode and burst control of the pseudo-static memory interface
// Contract
// - Register select high targets configuration
// - Wait polarity from bus configuration bit
// - Byte selects choose affected data lanes
// - Standby floats data and wait
// - Burst mode enabled by configuration bit
// - Synchronous reads ignore byte masking
// - Deep power-down on select rise, bit zero
// - Sync mode allows async writes too
// - Self-initialise defaults for 150 us
// - Page mode bit in refresh configuration
// - Address, direction captured on first edge
// - Burst lengths 4, 8, 16, 32, continuous
// - Continuous burst runs to row end
// - Latency count delays first word
// - Variable read latency, writes always fixed
// - Fixed latency includes refresh allowance
// - Wait during latency and row boundary
`timescale 1ns/1ps
module psbm_core #(
   parameter int INIT_CYCLES = psbm_pkg::INIT_CYCLES,
   parameter int ROW_WORDS = psbm_pkg::ROW_SHORT_WORDS
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire psbm_pkg::psbm_ctrl_t ctrl_i,
   input wire logic [psbm_pkg::ADDR_W-1:0] addr_i,
   input wire logic [psbm_pkg::DATA_W-1:0] dq_i,
   output logic [psbm_pkg::DATA_W-1:0] dq_o,
   output logic [1:0] dq_oe_o,
   output logic wait_o,
   output logic wait_oe_o,
   input wire logic refresh_busy_i,
   input wire logic [psbm_pkg::DATA_W-1:0] array_rdata_i,
   output logic array_valid_o,
   input wire logic array_ready_i,
   output psbm_pkg::psbm_word_t array_word_o,
   output logic array_write_o,
   output logic array_read_o,
   output logic [psbm_pkg::ADDR_W-1:0] array_raddr_o,
   output logic [15:0] bus_config_reg_o,
   output logic [15:0] refresh_config_reg_o,
   output logic page_mode_o,
   output logic deep_power_down_o,
   output logic init_done_o
);
   // ****************************************
   // Pin synchronisation
   // ****************************************
   psbm_pkg::psbm_ctrl_t cs;
   logic [psbm_pkg::ADDR_W-1:0] addr_s;
   logic [psbm_pkg::DATA_W-1:0] dq_s;
   logic refresh_s;

   psbm_sync3 #(.W(8), .INIT(8'hF6)) u_sync_ctrl (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .async_i(ctrl_i),
      .sync_o(cs)
   );
   psbm_sync3 #(.W(psbm_pkg::ADDR_W + psbm_pkg::DATA_W + 1)) u_sync_data (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .async_i({addr_i, dq_i, refresh_busy_i}),
      .sync_o({addr_s, dq_s, refresh_s})
   );

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [5:0] burst_words(input logic [2:0] len);
      case (len)
         psbm_pkg::LEN_4: burst_words = 6'h04;
         psbm_pkg::LEN_8: burst_words = 6'h08;
         psbm_pkg::LEN_16: burst_words = 6'h10;
         psbm_pkg::LEN_32: burst_words = 6'h20;
         default: burst_words = 6'h00;
      endcase
   endfunction

   function automatic logic [1:0] lanes(input logic ub_n, input logic lb_n);
      lanes = {~ub_n, ~lb_n};
   endfunction

   // ****************************************
   // State
   // ****************************************
   psbm_pkg::psbm_state_t st_q, st_d;
   logic [psbm_pkg::INIT_CNT_W-1:0] init_q, init_d;
   logic [15:0] bcr_q, bcr_d, rcr_q, rcr_d;
   logic [psbm_pkg::ADDR_W-1:0] baddr_q, baddr_d;
   logic bwrite_q, bwrite_d, breg_q, breg_d;
   logic [5:0] lat_q, lat_d, left_q, left_d;
   logic [psbm_pkg::DATA_W-1:0] dq_q, dq_d;
   logic [1:0] oe_q, oe_d;
   logic wait_act_q, wait_act_d;
   logic clk_prev_q, cs_prev_q, we_prev_q;
   logic clk_rise, cs_rise, cs_fall, we_rise;
   logic fifo_valid, fifo_ready;
   psbm_pkg::psbm_word_t fifo_word;
   logic [5:0] blen;
   logic at_row_end, burst_en, fixed_lat;

   assign clk_rise = cs.burst_clk && !clk_prev_q;
   assign cs_rise = cs.chip_select_n && !cs_prev_q;
   assign cs_fall = !cs.chip_select_n && cs_prev_q;
   assign we_rise = cs.write_enable_n && !we_prev_q;
   assign blen = burst_words(bcr_q[psbm_pkg::BCR_LEN_LSB +: 3]);
   assign burst_en = !bcr_q[psbm_pkg::BCR_MODE_BIT];
   assign fixed_lat = bcr_q[psbm_pkg::BCR_LAT_MODE_BIT];
   assign at_row_end = (baddr_q[7:0] & 8'(ROW_WORDS - 1)) == 8'(ROW_WORDS - 1);

   always_comb begin
      st_d = st_q;
      init_d = init_q;
      bcr_d = bcr_q;
      rcr_d = rcr_q;
      baddr_d = baddr_q;
      bwrite_d = bwrite_q;
      breg_d = breg_q;
      lat_d = lat_q;
      left_d = left_q;
      dq_d = dq_q;
      oe_d = '0;
      wait_act_d = wait_act_q;
      fifo_valid = 1'b0;
      fifo_word = '0;
      case (st_q)
         psbm_pkg::ST_INIT: begin
            // Defaults loaded at reset; pins ignored until count ends
            init_d = psbm_pkg::INIT_CNT_W'(init_q + 1'b1);
            if (init_q == psbm_pkg::INIT_CNT_W'(INIT_CYCLES - 1)) begin
               st_d = psbm_pkg::ST_IDLE;
            end
         end
         psbm_pkg::ST_IDLE: begin
            wait_act_d = 1'b0;
            if (!cs.chip_select_n && !cs.address_valid_n) begin
               if (burst_en && cs.burst_clk) begin
                  // Address and direction latched on first clocked edge
                  baddr_d = addr_s;
                  bwrite_d = !cs.write_enable_n;
                  breg_d = cs.register_select;
                  lat_d = 6'(bcr_q[psbm_pkg::BCR_LAT_LSB +: 3]);
                  // Writes and fixed reads add worst-case refresh allowance
                  if (fixed_lat || !cs.write_enable_n) begin
                     lat_d = 6'(lat_d + 6'(psbm_pkg::REFRESH_EXTRA));
                  end
                  left_d = cs.register_select ? 6'h01 : blen;
                  wait_act_d = 1'b1;
                  st_d = psbm_pkg::ST_LATENCY;
               end else if (!cs.burst_clk) begin
                  baddr_d = addr_s;
                  breg_d = cs.register_select;
                  bwrite_d = 1'b0;
                  st_d = psbm_pkg::ST_ASYNC;
               end
            end
         end
         psbm_pkg::ST_ASYNC: begin
            if (burst_en && clk_rise) begin
               st_d = psbm_pkg::ST_IDLE;
            end
            if (!cs.address_valid_n) begin
               baddr_d = addr_s;
            end
            if (!cs.write_enable_n) begin
               bwrite_d = 1'b1;
            end else if (!cs.output_enable_n) begin
               // Async read: register or array data on selected lanes
               oe_d = lanes(cs.upper_byte_select_n, cs.lower_byte_select_n);
               if (breg_q) begin
                  dq_d = (baddr_q[psbm_pkg::REG_SEL_LSB +: 2] == psbm_pkg::REG_SEL_BCR)
                     ? bcr_q : rcr_q;
               end else begin
                  dq_d = array_rdata_i;
               end
            end
            if (we_rise && bwrite_q) begin
               bwrite_d = 1'b0;
               if (breg_q) begin
                  if (baddr_q[psbm_pkg::REG_SEL_LSB +: 2] == psbm_pkg::REG_SEL_BCR) begin
                     bcr_d = addr_s[15:0];
                  end else begin
                     rcr_d = addr_s[15:0];
                  end
               end else begin
                  fifo_valid = 1'b1;
                  fifo_word.addr = baddr_q;
                  fifo_word.data = dq_s;
                  fifo_word.byte_en = lanes(cs.upper_byte_select_n,
                     cs.lower_byte_select_n);
               end
            end
         end
         psbm_pkg::ST_LATENCY: begin
            // Variable read latency stretched while refresh busy
            if (clk_rise && !(refresh_s && !fixed_lat && !bwrite_q)) begin
               if (lat_q <= 6'h01) begin
                  wait_act_d = 1'b0;
                  st_d = psbm_pkg::ST_BURST;
               end else begin
                  lat_d = 6'(lat_q - 1'b1);
               end
            end
         end
         psbm_pkg::ST_BURST: begin
            // Stopped clock holds the burst: nothing advances
            if (!bwrite_q && !cs.output_enable_n) begin
               oe_d = 2'h3;
               dq_d = breg_q ? ((baddr_q[psbm_pkg::REG_SEL_LSB +: 2] ==
                  psbm_pkg::REG_SEL_BCR) ? bcr_q : rcr_q) : array_rdata_i;
            end
            if (clk_rise && !wait_act_q) begin
               if (bwrite_q) begin
                  if (breg_q) begin
                     if (baddr_q[psbm_pkg::REG_SEL_LSB +: 2] == psbm_pkg::REG_SEL_BCR) begin
                        bcr_d = baddr_q[15:0];
                     end else begin
                        rcr_d = baddr_q[15:0];
                     end
                  end else begin
                     fifo_valid = 1'b1;
                     fifo_word.addr = baddr_q;
                     fifo_word.data = dq_s;
                     fifo_word.byte_en = lanes(cs.upper_byte_select_n,
                        cs.lower_byte_select_n);
                  end
               end
               if (left_q == 6'h01) begin
                  wait_act_d = 1'b1;
               end else if (left_q == 6'h00 && at_row_end) begin
                  wait_act_d = 1'b1;
               end else begin
                  // Fixed bursts wrap inside their length
                  baddr_d = (left_q == 6'h00) ? psbm_pkg::ADDR_W'(baddr_q + 1'b1) :
                     {baddr_q[psbm_pkg::ADDR_W-1:5],
                      (baddr_q[4:0] & ~5'(blen - 1'b1)) |
                      (5'(baddr_q[4:0] + 1'b1) & 5'(blen - 1'b1))};
                  if (left_q != 6'h00) begin
                     left_d = 6'(left_q - 1'b1);
                  end
               end
            end
         end
         psbm_pkg::ST_DPD: begin
            wait_act_d = 1'b0;
            if (cs_fall) begin
               rcr_d[psbm_pkg::RCR_DPD_BIT] = 1'b1;
               st_d = psbm_pkg::ST_IDLE;
            end
         end
         default: st_d = psbm_pkg::ST_IDLE;
      endcase
      // Deselect ends any cycle; deep power-down if enabled
      if (st_q != psbm_pkg::ST_INIT && st_q != psbm_pkg::ST_DPD && cs.chip_select_n) begin
         oe_d = '0;
         wait_act_d = 1'b0;
         st_d = (cs_rise && !rcr_d[psbm_pkg::RCR_DPD_BIT]) ? psbm_pkg::ST_DPD :
            psbm_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         st_q <= psbm_pkg::ST_INIT;
         init_q <= '0;
         bcr_q <= psbm_pkg::BCR_RESET;
         rcr_q <= psbm_pkg::RCR_RESET;
         baddr_q <= '0;
         bwrite_q <= 1'b0;
         breg_q <= 1'b0;
         lat_q <= '0;
         left_q <= '0;
         dq_q <= '0;
         oe_q <= '0;
         wait_act_q <= 1'b0;
         clk_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
         we_prev_q <= 1'b1;
      end else begin
         st_q <= st_d;
         init_q <= init_d;
         bcr_q <= bcr_d;
         rcr_q <= rcr_d;
         baddr_q <= baddr_d;
         bwrite_q <= bwrite_d;
         breg_q <= breg_d;
         lat_q <= lat_d;
         left_q <= left_d;
         dq_q <= dq_d;
         oe_q <= oe_d;
         wait_act_q <= wait_act_d;
         clk_prev_q <= cs.burst_clk;
         cs_prev_q <= cs.chip_select_n;
         we_prev_q <= cs.write_enable_n;
      end
   end

   // ****************************************
   // Write path buffer
   // ****************************************
   // Full buffer drops words; array drain must keep pace with bursts
   psbm_fifo #(.WIDTH($bits(psbm_pkg::psbm_word_t)), .DEPTH(psbm_pkg::FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .in_valid_i(fifo_valid),
      .in_ready_o(fifo_ready),
      .in_data_i(fifo_word),
      .out_valid_o(array_valid_o),
      .out_ready_i(array_ready_i),
      .out_data_o(array_word_o)
   );

   assign array_write_o = fifo_valid && fifo_ready;
   assign array_read_o = (st_q == psbm_pkg::ST_ASYNC || st_q == psbm_pkg::ST_BURST) &&
      !bwrite_q && !breg_q;
   assign array_raddr_o = baddr_q;
   assign dq_o = dq_q;
   assign dq_oe_o = oe_q;
   // Wait floats under deselect, level set by polarity bit
   assign wait_oe_o = !cs.chip_select_n && st_q != psbm_pkg::ST_INIT &&
      st_q != psbm_pkg::ST_DPD;
   assign wait_o = wait_act_q ~^ bcr_q[psbm_pkg::BCR_WAIT_POL_BIT];
   assign bus_config_reg_o = bcr_q;
   assign refresh_config_reg_o = rcr_q;
   assign page_mode_o = rcr_q[psbm_pkg::RCR_PAGE_BIT];
   assign deep_power_down_o = (st_q == psbm_pkg::ST_DPD);
   assign init_done_o = (st_q != psbm_pkg::ST_INIT);
endmodule

// File: src/psbm_pkg.sv
// Package of constants and carrier types for the pseudo-static bus mode and burst block
package psbm_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ = 25;
   localparam int INIT_TIME_US = 150;
   localparam int INIT_CYCLES = INIT_TIME_US * CLK_MHZ;
   localparam int INIT_CNT_W = 13;
   localparam int ROW_SHORT_WORDS = 128;
   localparam int ROW_LONG_WORDS = 256;
   localparam int REFRESH_EXTRA = 2;
   localparam int FIFO_DEPTH = 8;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 22;

   // ****************************************
   // Bus configuration fields
   // ****************************************
   localparam int BCR_MODE_BIT = 15;
   localparam int BCR_LAT_MODE_BIT = 14;
   localparam int BCR_LAT_LSB = 11;
   localparam int BCR_WAIT_POL_BIT = 10;
   localparam int BCR_LEN_LSB = 0;
   localparam logic [15:0] BCR_RESET = 16'h9D1F;
   localparam logic [2:0] LEN_4 = 3'h1;
   localparam logic [2:0] LEN_8 = 3'h2;
   localparam logic [2:0] LEN_16 = 3'h3;
   localparam logic [2:0] LEN_32 = 3'h4;
   localparam logic [2:0] LEN_CONT = 3'h7;

   // ****************************************
   // Refresh configuration fields
   // ****************************************
   localparam int RCR_PAGE_BIT = 7;
   localparam int RCR_DPD_BIT = 4;
   localparam logic [15:0] RCR_RESET = 16'h0010;
   localparam logic [1:0] REG_SEL_RCR = 2'h0;
   localparam logic [1:0] REG_SEL_BCR = 2'h2;
   localparam int REG_SEL_LSB = 18;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic chip_select_n;
      logic output_enable_n;
      logic write_enable_n;
      logic address_valid_n;
      logic register_select;
      logic upper_byte_select_n;
      logic lower_byte_select_n;
      logic burst_clk;
   } psbm_ctrl_t;

   typedef struct packed {
      logic [1:0] byte_en;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } psbm_word_t;

   typedef enum logic [5:0] {
      ST_INIT = 6'h01,
      ST_IDLE = 6'h02,
      ST_ASYNC = 6'h04,
      ST_LATENCY = 6'h08,
      ST_BURST = 6'h10,
      ST_DPD = 6'h20
   } psbm_state_t;
endpackage

// File: src/psbm_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module psbm_sync3 #(
   parameter int W = 8,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] s1_q, s2_q, s3_q, out_q;
   logic [W-1:0] s1_d, s2_d, s3_d, out_d;

   always_comb begin
      s1_d = async_i;
      s2_d = s1_q;
      s3_d = s2_q;
      // Change counts only once stages two and three agree
      out_d = out_q;
      for (int i = 0; i < W; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            out_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
         out_q <= INIT;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         out_q <= out_d;
      end
   end

   assign sync_o = out_q;
endmodule

// File: src/psbm_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
module psbm_fifo #(
   parameter int WIDTH = 40,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   always_comb begin
      push = in_valid_i && (cnt_q != AW'(0) + (AW+1)'(DEPTH));
      pop = out_ready_i && (cnt_q != '0);
      wr_d = push ? AW'(wr_q + AW'(1)) : wr_q;
      rd_d = pop ? AW'(rd_q + AW'(1)) : rd_q;
      cnt_d = (AW+1)'(cnt_q + (AW+1)'(push) - (AW+1)'(pop));
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rd_q];
endmodule

// File: testbench/psbm_checker.sv
// Assertion checker for the bus mode and burst block
`timescale 1ns/1ps
module psbm_checker #(
   parameter int INIT_CYCLES = 3750,
   parameter int ROW_WORDS = 128
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire psbm_pkg::psbm_ctrl_t ctrl_i,
   input wire logic [psbm_pkg::ADDR_W-1:0] addr_i,
   input wire logic [psbm_pkg::DATA_W-1:0] dq_i,
   input wire logic [psbm_pkg::DATA_W-1:0] dq_o,
   input wire logic [1:0] dq_oe_o,
   input wire logic wait_o,
   input wire logic wait_oe_o,
   input wire logic refresh_busy_i,
   input wire logic [psbm_pkg::DATA_W-1:0] array_rdata_i,
   input wire logic array_valid_o,
   input wire logic array_ready_i,
   input wire psbm_pkg::psbm_word_t array_word_o,
   input wire logic array_write_o,
   input wire logic array_read_o,
   input wire logic [psbm_pkg::ADDR_W-1:0] array_raddr_o,
   input wire logic [15:0] bus_config_reg_o,
   input wire logic [15:0] refresh_config_reg_o,
   input wire logic page_mode_o,
   input wire logic deep_power_down_o,
   input wire logic init_done_o
);
   // ****************************************
   // Helper logic and sequences
   // ****************************************
   int init_cnt_q;
   int init_cnt_d;
   always_comb begin
      init_cnt_d = init_done_o ? init_cnt_q : init_cnt_q + 1;
   end
   always_ff @(posedge clk_i) begin
      if (!reset_n_i)
         init_cnt_q <= 0;
      else
         init_cnt_q <= init_cnt_d;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // Six cycles covers the pin filter lag plus one register stage
   sequence s_select_high;
      ctrl_i.chip_select_n [*6];
   endsequence
   sequence s_select_low;
      !ctrl_i.chip_select_n [*6];
   endsequence
   // ****************************************
   // Properties
   // ****************************************
   property p_standby_float;
      s_select_high |-> !wait_oe_o && dq_oe_o == 2'h0;
   endproperty
   a_standby_float: assert property (p_standby_float)
      else $error("outputs driven while deselected");
   property p_select_drive;
      s_select_low ##0 (init_done_o && !deep_power_down_o) |-> wait_oe_o;
   endproperty
   a_select_drive: assert property (p_select_drive)
      else $error("wait not driven while selected");
   property p_init_defaults;
      !init_done_o |-> bus_config_reg_o == psbm_pkg::BCR_RESET
         && refresh_config_reg_o == psbm_pkg::RCR_RESET;
   endproperty
   a_init_defaults: assert property (p_init_defaults)
      else $error("configuration not at defaults during start-up");
   property p_init_quiet;
      !init_done_o |-> !array_write_o && !array_read_o && dq_oe_o == 2'h0;
   endproperty
   a_init_quiet: assert property (p_init_quiet)
      else $error("activity during start-up");
   property p_init_time;
      $rose(init_done_o) |-> init_cnt_q >= INIT_CYCLES - 1 && init_cnt_q <= INIT_CYCLES + 2;
   endproperty
   a_init_time: assert property (p_init_time)
      else $error("start-up length wrong");
   property p_page_mode;
      page_mode_o == refresh_config_reg_o[psbm_pkg::RCR_PAGE_BIT];
   endproperty
   a_page_mode: assert property (p_page_mode)
      else $error("page mode does not follow its bit");
   property p_dpd_entry;
      $rose(deep_power_down_o) |-> ctrl_i.chip_select_n
         && !refresh_config_reg_o[psbm_pkg::RCR_DPD_BIT];
   endproperty
   a_dpd_entry: assert property (p_dpd_entry)
      else $error("power-down entered without cause");
   property p_dpd_hold;
      deep_power_down_o && ctrl_i.chip_select_n |=> deep_power_down_o;
   endproperty
   a_dpd_hold: assert property (p_dpd_hold)
      else $error("power-down left while deselected");
endmodule

bind psbm_core psbm_checker #(.INIT_CYCLES(INIT_CYCLES), .ROW_WORDS(ROW_WORDS)) i_checker (
   .clk_i(clk_i), .reset_n_i(reset_n_i), .ctrl_i(ctrl_i), .addr_i(addr_i), .dq_i(dq_i),
   .dq_o(dq_o), .dq_oe_o(dq_oe_o), .wait_o(wait_o), .wait_oe_o(wait_oe_o),
   .refresh_busy_i(refresh_busy_i), .array_rdata_i(array_rdata_i),
   .array_valid_o(array_valid_o), .array_ready_i(array_ready_i),
   .array_word_o(array_word_o), .array_write_o(array_write_o), .array_read_o(array_read_o),
   .array_raddr_o(array_raddr_o), .bus_config_reg_o(bus_config_reg_o),
   .refresh_config_reg_o(refresh_config_reg_o), .page_mode_o(page_mode_o),
   .deep_power_down_o(deep_power_down_o), .init_done_o(init_done_o)
);

// File: testbench/psbm_host_model.sv
// Bus master model that drives the memory pins
`timescale 1ns/1ps
module psbm_host_model (
   input wire logic clk_i,
   input wire logic wait_i,
   input wire logic [15:0] rdq_i,
   input wire logic [1:0] rdq_oe_i,
   output psbm_pkg::psbm_ctrl_t ctrl_o,
   output logic [psbm_pkg::ADDR_W-1:0] addr_o,
   output logic [psbm_pkg::DATA_W-1:0] dq_o
);
   // ****************************************
   // Pin sequences
   // ****************************************
   initial begin
      ctrl_o = 8'hF6;
      addr_o = '0;
      dq_o = 16'h0000;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // Each level held six cycles so the pin filter agrees
   task automatic tick();
      ctrl_o.burst_clk = 1'b1;
      step(6);
      ctrl_o.burst_clk = 1'b0;
      step(6);
   endtask
   // Released data lines must not keep showing the old word
   task automatic park();
      ctrl_o = 8'hF6;
      dq_o = ~dq_o;
      step(8);
   endtask
   task automatic cyc(input logic wr, input logic rs, input logic [1:0] be_n,
         input logic [21:0] a, input logic [15:0] d, output logic [17:0] q);
      ctrl_o.register_select = rs;
      ctrl_o.upper_byte_select_n = be_n[1];
      ctrl_o.lower_byte_select_n = be_n[0];
      ctrl_o.address_valid_n = 1'b0;
      ctrl_o.write_enable_n = !wr;
      ctrl_o.output_enable_n = wr;
      addr_o = a;
      dq_o = d;
      ctrl_o.chip_select_n = 1'b0;
      step(10);
      q = {rdq_oe_i, rdq_i};
      ctrl_o.write_enable_n = 1'b1;
      step(6);
      park();
   endtask
   // Latency counted in clock rises until wait drops
   task automatic burst(input logic wr, input logic pol, output int lat);
      ctrl_o.upper_byte_select_n = 1'b0;
      ctrl_o.lower_byte_select_n = 1'b0;
      ctrl_o.address_valid_n = 1'b0;
      ctrl_o.write_enable_n = !wr;
      ctrl_o.output_enable_n = wr;
      addr_o = 22'h000040;
      ctrl_o.chip_select_n = 1'b0;
      step(6);
      tick();
      ctrl_o.address_valid_n = 1'b1;
      lat = 0;
      while (wait_i === pol && lat < 40) begin
         tick();
         lat++;
      end
      for (int k = 0; k < 4; k++) begin
         dq_o = 16'(16'hB000 + k);
         if (k == 2 && !wr) begin
            ctrl_o.output_enable_n = 1'b1;
            step(8);
            ctrl_o.output_enable_n = 1'b0;
            step(6);
         end
         tick();
      end
      park();
   endtask
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the bus mode and burst block
`timescale 1ns/1ps
module tb_top;
   localparam int INIT_SIM = 20;
   logic clk_i, reset_n_i, refresh_busy, array_ready;
   psbm_pkg::psbm_ctrl_t ctrl;
   psbm_pkg::psbm_word_t word;
   logic [21:0] addr, raddr;
   logic [15:0] dq_in, dq_out, bus_config_reg, refresh_config_reg, rdata, m;
   logic [1:0] dq_oe;
   logic wait_o, wait_oe, valid, wr_pulse, rd_act, page, deep_power_down, done, rd_seen;
   logic [17:0] q;
   logic [1:0] lanes [3] = '{2'b00, 2'b10, 2'b01};
   logic [15:0] bcrv [3] = '{16'h5D19, 16'h1919, 16'h1D19};
   int latx [3] = '{5, 4, 5};
   int miscompares, num_checks, pushes, cycles, lat, p0;
   assign rdata = raddr[15:0] ^ 16'h5A5A;
   psbm_core #(.INIT_CYCLES(INIT_SIM)) i_dut (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .ctrl_i(ctrl), .addr_i(addr), .dq_i(dq_in),
      .dq_o(dq_out), .dq_oe_o(dq_oe), .wait_o(wait_o), .wait_oe_o(wait_oe),
      .refresh_busy_i(refresh_busy), .array_rdata_i(rdata), .array_valid_o(valid),
      .array_ready_i(array_ready), .array_word_o(word), .array_write_o(wr_pulse),
      .array_read_o(rd_act), .array_raddr_o(raddr), .bus_config_reg_o(bus_config_reg),
      .refresh_config_reg_o(refresh_config_reg), .page_mode_o(page), .deep_power_down_o(deep_power_down),
      .init_done_o(done)
   );
   psbm_host_model i_host (
      .clk_i(clk_i), .wait_i(wait_o), .rdq_i(dq_out), .rdq_oe_i(dq_oe),
      .ctrl_o(ctrl), .addr_o(addr), .dq_o(dq_in)
   );
   // ****************************************
   // Clock, monitor and reporting
   // ****************************************
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (wr_pulse === 1'b1)
         pushes++;
      if (rd_act === 1'b1)
         rd_seen = 1'b1;
      if (cycles == 6000) begin
         miscompares++;
         final_report();
      end
   end
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (miscompares == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      reset_n_i = 1'b0;
      refresh_busy = 1'b0;
      array_ready = 1'b0;
      rd_seen = 1'b0;
      repeat (16) @(posedge clk_i);
      #1;
      reset_n_i = 1'b1;
      check(bus_config_reg, psbm_pkg::BCR_RESET);
      check(refresh_config_reg, psbm_pkg::RCR_RESET);
      check(done, 1'b0);
      i_host.step(INIT_SIM + 4);
      check(done, 1'b1);
      // Far side stalled, so the ninth write finds the buffer full
      for (int i = 0; i < 9; i++)
         i_host.cyc(1'b1, 1'b0, lanes[i % 3], 22'(22'h100 + i), 16'(16'hC000 + i), q);
      check(pushes, 8);
      for (int i = 0; i < 8; i++) begin
         check(valid, 1'b1);
         check(word, {~lanes[i % 3], 22'(22'h100 + i), 16'(16'hC000 + i)});
         array_ready = 1'b1;
         i_host.step(1);
         array_ready = 1'b0;
         i_host.step(1);
      end
      check(valid, 1'b0);
      for (int i = 0; i < 3; i++) begin
         m = {{8{~lanes[i][1]}}, {8{~lanes[i][0]}}};
         i_host.cyc(1'b0, 1'b0, lanes[i], 22'(22'h2A0 + i), 16'h0000, q);
         check({q[17:16], q[15:0] & m}, {~lanes[i], (16'(16'h2A0 + i) ^ 16'h5A5A) & m});
      end
      p0 = pushes;
      i_host.cyc(1'b1, 1'b1, 2'b00, 22'h000090, 16'h0000, q);
      check(refresh_config_reg, 16'h0090);
      check(page, 1'b1);
      check(pushes, p0);
      i_host.cyc(1'b0, 1'b1, 2'b00, 22'h000000, 16'h0000, q);
      check(q[15:0], 16'h0090);
      i_host.cyc(1'b1, 1'b1, 2'b00, 22'h000000, 16'h0000, q);
      check(deep_power_down, 1'b1);
      i_host.cyc(1'b0, 1'b0, 2'b00, 22'h000010, 16'h0000, q);
      check(deep_power_down, 1'b0);
      check(refresh_config_reg[4], 1'b1);
      // Fixed read, variable read, then a write that ignores the variable setting
      p0 = pushes;
      rd_seen = 1'b0;
      for (int i = 0; i < 3; i++) begin
         i_host.cyc(1'b1, 1'b1, 2'b00, 22'(22'h080000 | bcrv[i]), 16'h0000, q);
         check(bus_config_reg, bcrv[i]);
         refresh_busy = (i == 1);
         fork
            i_host.burst(i == 2, bcrv[i][10], lat);
            begin
               i_host.step(24);
               refresh_busy = 1'b0;
            end
         join
         check(lat, latx[i]);
      end
      check(rd_seen, 1'b1);
      check(pushes - p0, 4);
      check(word, {2'h3, 22'h000040, 16'hB000});
      i_host.cyc(1'b1, 1'b0, 2'b00, 22'h000300, 16'h1234, q);
      check(pushes - p0, 5);
      final_report();
   end
endmodule
